/* File: fpc_defines.svh */
// Constants for the fault indicator and configuration boot block.
// Assumes a 20 MHz core clock; included by fpc_pkg.sv and every module but tb_top.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
`define FPC_CLK_HZ 20000000
`define FPC_PWM_HZ 16
`define FPC_PWM_PERIOD (`FPC_CLK_HZ / `FPC_PWM_HZ)
`define FPC_LOW_AMP_PCT 75
`define FPC_OVERSPEED_PCT 50
`define FPC_LOW_AMP_NUM 1
`define FPC_LOW_AMP_DEN 10
`define FPC_RES_SMALL_LIMIT 4096
`define FPC_OVERSPEED_HZ_SMALL 1000
`define FPC_CFG_BYTES 128
`define FPC_I2C_HZ 100000
`define FPC_I2C_QTR (`FPC_CLK_HZ / (4 * `FPC_I2C_HZ))
`define FPC_EE_DEV_WR 8'ha0
`define FPC_EE_DEV_RD 8'ha1
`define FPC_EE_START_ADDR 8'h00
`endif

/* File: fpc_pkg.sv */
// Types shared by the fault indicator and the configuration loader.
// Assumes fpc_defines.svh is reachable by bare name.
`include "fpc_defines.svh"
package fpc_pkg;
   typedef enum logic [1:0] {
      FPC_FLT_NONE = 2'h0,
      FPC_FLT_OVERSPEED = 2'h1,
      FPC_FLT_LOW_AMP = 2'h3,
      FPC_FLT_CFG = 2'h2
   } fpc_fault_e;
   typedef enum logic [3:0] {
      FPC_LD_IDLE = 4'h0,
      FPC_LD_START = 4'h1,
      FPC_LD_BYTE = 4'h3,
      FPC_LD_ACK = 4'h2,
      FPC_LD_RSTART = 4'h6,
      FPC_LD_READ = 4'h7,
      FPC_LD_MACK = 4'h5,
      FPC_LD_STOP = 4'h4,
      FPC_LD_DONE = 4'hc,
      FPC_LD_FAIL = 4'hd
   } fpc_load_e;
endpackage

/* File: fpc_cfg_loader.sv */
// Boot loader: reads the configuration image from a two-wire EEPROM.
// Assumes open-drain scl/sda with pull-ups; sda_i arrives already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_cfg_loader #(
   parameter int CFG_BYTES = `FPC_CFG_BYTES,
   parameter int QTR = `FPC_I2C_QTR
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   output logic scl_oe_o,
   output logic cfg_we_o,
   output logic [6:0] cfg_addr_o,
   output logic [7:0] cfg_data_o,
   output logic done_o,
   output logic fail_o
);
   import fpc_pkg::*;
   fpc_load_e st_reg, st_next;
   logic [15:0] q_reg, q_next;
   logic [1:0] ph_reg, ph_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [1:0] step_reg, step_next;
   logic [7:0] cnt_reg, cnt_next;
   logic sda_reg, sda_next, scl_reg, scl_next, we_reg, we_next;
   logic tick;
   assign tick = (q_reg == 16'(QTR - 1));
   // ---------------------------------------------------------------
   // Bit engine: four phases per bit, sda changes only while scl low, except for start and stop.
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      q_next = tick ? 16'h0000 : q_reg + 16'h0001;
      ph_next = ph_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      step_next = step_reg;
      cnt_next = cnt_reg;
      sda_next = sda_reg;
      scl_next = scl_reg;
      we_next = 1'b0;
      if (tick) begin
         ph_next = ph_reg + 2'h1;
         case (st_reg)
            FPC_LD_IDLE: begin
               sda_next = 1'b1;
               scl_next = 1'b1;
               if (ph_reg == 2'h3) st_next = FPC_LD_START;
            end
            FPC_LD_START, FPC_LD_RSTART: begin
               if (ph_reg == 2'h0) begin
                  sda_next = 1'b1;
                  scl_next = 1'b1;
               end else if (ph_reg == 2'h1) sda_next = 1'b0;
               else if (ph_reg == 2'h2) scl_next = 1'b0;
               else begin
                  st_next = FPC_LD_BYTE;
                  bit_next = 4'h0;
                  sh_next = (st_reg == FPC_LD_START) ? `FPC_EE_DEV_WR : `FPC_EE_DEV_RD;
               end
            end
            FPC_LD_BYTE, FPC_LD_READ: begin
               if (ph_reg == 2'h0) sda_next = (st_reg == FPC_LD_READ) ? 1'b1 : sh_reg[7];
               else if (ph_reg == 2'h1) scl_next = 1'b1;
               else if (ph_reg == 2'h2) begin
                  if (st_reg == FPC_LD_READ) sh_next = {sh_reg[6:0], sda_i};
               end else begin
                  scl_next = 1'b0;
                  if (st_reg == FPC_LD_BYTE) sh_next = {sh_reg[6:0], 1'b0};
                  bit_next = bit_reg + 4'h1;
                  if (bit_reg == 4'h7) st_next = (st_reg == FPC_LD_BYTE) ? FPC_LD_ACK : FPC_LD_MACK;
               end
            end
            FPC_LD_ACK: begin
               if (ph_reg == 2'h0) sda_next = 1'b1;
               else if (ph_reg == 2'h1) scl_next = 1'b1;
               else if (ph_reg == 2'h2) begin
                  if (sda_i) st_next = FPC_LD_FAIL;
               end else begin
                  scl_next = 1'b0;
                  bit_next = 4'h0;
                  step_next = step_reg + 2'h1;
                  if (step_reg == 2'h0) begin
                     st_next = FPC_LD_BYTE;
                     sh_next = `FPC_EE_START_ADDR;
                  end else if (step_reg == 2'h1) st_next = FPC_LD_RSTART;
                  else st_next = FPC_LD_READ;
               end
            end
            FPC_LD_MACK: begin
               if (ph_reg == 2'h0) begin
                  sda_next = (cnt_reg == 8'(CFG_BYTES - 1)); // Nack the last byte.
                  we_next = 1'b1;
               end else if (ph_reg == 2'h1) scl_next = 1'b1;
               else if (ph_reg == 2'h3) begin
                  scl_next = 1'b0;
                  bit_next = 4'h0;
                  cnt_next = cnt_reg + 8'h01;
                  st_next = (cnt_reg == 8'(CFG_BYTES - 1)) ? FPC_LD_STOP : FPC_LD_READ;
               end
            end
            FPC_LD_STOP: begin
               if (ph_reg == 2'h0) sda_next = 1'b0;
               else if (ph_reg == 2'h1) scl_next = 1'b1;
               else if (ph_reg == 2'h2) sda_next = 1'b1;
               else st_next = FPC_LD_DONE;
            end
            FPC_LD_FAIL: begin
               // Release the bus; the fault is permanent until reset.
               sda_next = 1'b1;
               scl_next = 1'b1;
            end
            FPC_LD_DONE: begin
               sda_next = 1'b1;
               scl_next = 1'b1;
            end
            default: st_next = FPC_LD_FAIL;
         endcase
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         st_reg <= FPC_LD_IDLE;
         q_reg <= 16'h0000;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         step_reg <= 2'h0;
         cnt_reg <= 8'h00;
         sda_reg <= 1'b1;
         scl_reg <= 1'b1;
         we_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         q_reg <= q_next;
         ph_reg <= ph_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         step_reg <= step_next;
         cnt_reg <= cnt_next;
         sda_reg <= sda_next;
         scl_reg <= scl_next;
         we_reg <= we_next;
      end
   end
   assign sda_oe_o = ~sda_reg;
   assign scl_oe_o = ~scl_reg;
   assign cfg_we_o = we_reg;
   assign cfg_addr_o = cnt_reg[6:0];
   assign cfg_data_o = sh_reg;
   assign done_o = (st_reg == FPC_LD_DONE);
   assign fail_o = (st_reg == FPC_LD_FAIL);
   ack_missing_fail_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      st_reg == FPC_LD_ACK && tick && ph_reg == 2'h2 && sda_i |=> fail_o)
      else $error("Missing acknowledge did not fail the load.");
endmodule
`default_nettype wire

/* File: fpc_fault_pwm.sv */
// Fault indicator driver with boot-time configuration load.
// Assumes amplitude, frequency and resolution inputs come from the same clock
// domain; the EEPROM data line is a pin and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_fault_pwm #(
   parameter int PWM_PERIOD = `FPC_PWM_PERIOD,
   parameter int I2C_QTR = `FPC_I2C_QTR,
   parameter int CFG_BYTES = `FPC_CFG_BYTES,
   parameter int AMP_W = 12,
   parameter int FREQ_W = 20
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [AMP_W-1:0] amp_i,
   input wire logic [AMP_W-1:0] supply_i,
   input wire logic [FREQ_W-1:0] freq_hz_i,
   input wire logic [FREQ_W-1:0] freq_max_hz_i,
   input wire logic [13:0] resolution_i,
   input wire logic ee_sda_i,
   output logic ee_sda_o,
   output logic ee_sda_oe_o,
   output logic ee_scl_o,
   output logic ee_scl_oe_o,
   output logic fault_n_o,
   output fpc_pkg::fpc_fault_e fault_kind_o,
   output logic cfg_ready_o,
   output logic cfg_we_o,
   output logic [6:0] cfg_addr_o,
   output logic [7:0] cfg_data_o
);
   import fpc_pkg::*;
   // ---------------------------------------------------------------
   // Pin synchroniser and configuration loader.
   // ---------------------------------------------------------------
   logic sda_s1_reg, sda_s2_reg;
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         sda_s1_reg <= ee_sda_i;
         sda_s2_reg <= sda_s1_reg;
      end
   end
   logic ld_done, ld_fail;
   fpc_cfg_loader #(
      .CFG_BYTES(CFG_BYTES),
      .QTR(I2C_QTR)
   ) u_loader (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .sda_i(sda_s2_reg),
      .sda_oe_o(ee_sda_oe_o),
      .scl_oe_o(ee_scl_oe_o),
      .cfg_we_o(cfg_we_o),
      .cfg_addr_o(cfg_addr_o),
      .cfg_data_o(cfg_data_o),
      .done_o(ld_done),
      .fail_o(ld_fail)
   );
   assign ee_sda_o = 1'b0;
   assign ee_scl_o = 1'b0;
   assign cfg_ready_o = ld_done;
   // ---------------------------------------------------------------
   // Fault detection.
   // ---------------------------------------------------------------
   function automatic logic over_speed(input logic [FREQ_W-1:0] f,
                                       input logic [FREQ_W-1:0] fmax,
                                       input logic [13:0] res);
      logic [FREQ_W-1:0] lim;
      lim = (res < 14'(`FPC_RES_SMALL_LIMIT)) ? FREQ_W'(`FPC_OVERSPEED_HZ_SMALL) : fmax;
      return f > lim;
   endfunction
   logic low_amp, fast;
   // One-sided compare: a strong signal never flags.
   assign low_amp = ({4'h0, amp_i} * (AMP_W + 4)'(`FPC_LOW_AMP_DEN))
                    < ({4'h0, supply_i} * (AMP_W + 4)'(`FPC_LOW_AMP_NUM));
   assign fast = over_speed(freq_hz_i, freq_max_hz_i, resolution_i);
   // ---------------------------------------------------------------
   // Fault selection and 16 Hz PWM.
   // ---------------------------------------------------------------
   fpc_fault_e kind_reg, kind_next;
   logic [23:0] per_reg, per_next;
   logic out_reg, out_next;
   logic [23:0] low_len;
   always_comb begin
      if (!ld_done && !ld_fail) kind_next = FPC_FLT_NONE;
      else if (ld_fail) kind_next = FPC_FLT_CFG;
      else if (low_amp) kind_next = FPC_FLT_LOW_AMP;
      else if (fast) kind_next = FPC_FLT_OVERSPEED;
      else kind_next = FPC_FLT_NONE;
      per_next = (per_reg == 24'(PWM_PERIOD - 1)) ? 24'h000000 : per_reg + 24'h000001;
      case (kind_reg)
         FPC_FLT_LOW_AMP: low_len = 24'(PWM_PERIOD * `FPC_LOW_AMP_PCT / 100);
         FPC_FLT_OVERSPEED: low_len = 24'(PWM_PERIOD * `FPC_OVERSPEED_PCT / 100);
         default: low_len = 24'h000000;
      endcase
      case (kind_reg)
         FPC_FLT_NONE: out_next = 1'b1;
         FPC_FLT_CFG: out_next = 1'b0;
         default: out_next = (per_reg >= low_len);
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         kind_reg <= FPC_FLT_NONE;
         per_reg <= 24'h000000;
         out_reg <= 1'b1;
      end else begin
         kind_reg <= kind_next;
         per_reg <= per_next;
         out_reg <= out_next;
      end
   end
   assign fault_n_o = out_reg;
   assign fault_kind_o = kind_reg;
   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   sequence cfg_failed_s;
      kind_reg == FPC_FLT_CFG;
   endsequence
   no_fault_high_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      kind_reg == FPC_FLT_NONE |=> fault_n_o) else $error("Indicator low without fault.");
   cfg_fail_low_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      cfg_failed_s |=> !fault_n_o) else $error("Indicator not low after load failure.");
   cfg_fail_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      cfg_failed_s |=> cfg_failed_s) else $error("Load failure cleared.");
   pwm_low_start_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (per_reg == 24'h000000 && $stable(kind_reg) && kind_reg inside {FPC_FLT_LOW_AMP,
      FPC_FLT_OVERSPEED}) |=> !fault_n_o) else $error("Period did not start low.");
   amp_duty_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      kind_reg == FPC_FLT_LOW_AMP && per_reg == 24'(PWM_PERIOD * 3 / 4) && $stable(kind_reg)
      |=> fault_n_o) else $error("Amplitude duty wrong.");
   speed_duty_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      kind_reg == FPC_FLT_OVERSPEED && per_reg == 24'(PWM_PERIOD / 2 - 1)
      |=> !fault_n_o) else $error("Over-speed duty wrong.");
   small_res_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ld_done && !low_amp && resolution_i < 14'h1000 && freq_hz_i > FREQ_W'(1000)
      |=> kind_reg == FPC_FLT_OVERSPEED) else $error("Small-resolution threshold missed.");
   amp_priority_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ld_done && low_amp && fast |=> kind_reg == FPC_FLT_LOW_AMP)
      else $error("Over-speed shown over amplitude.");
   strong_ok_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      amp_i >= supply_i |-> !low_amp) else $error("Strong signal flagged.");
   nack_fail_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(ld_fail) |-> !ld_done ##2 !fault_n_o) else $error("Fail with done.");
endmodule
`default_nettype wire

/* File: fpc_ee_model.sv */
// Behavioural two-wire configuration memory for the boot loader bench.
// Assumes the bench resolves the pulled-up lines; sda_oe_o high pulls sda low.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_ee_model #(
   parameter int MEM_BYTES = 128
) (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nack_i,
   output logic sda_oe_o
);
   // ----------------------------------------
   // Storage and bit state
   // ----------------------------------------
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'h00;
   logic [6:0] ptr = 7'h00;
   int bitn = 0;
   logic act = 1'b0;
   logic rd = 1'b0;
   logic first = 1'b0;
   logic go_rd = 1'b0;
   logic ok = 1'b0;
   initial sda_oe_o = 1'b0;
   // ----------------------------------------
   // Line conditions and bit handling
   // ----------------------------------------
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      act = 1'b1;
      bitn = 0;
      rd = 1'b0;
      first = 1'b1;
   end
   always @(posedge sda_i) if (scl_i === 1'b1) begin
      act = 1'b0;
      sda_oe_o = 1'b0;
   end
   always @(posedge scl_i) if (act) begin
      if (bitn < 8) sh = {sh[6:0], sda_i};
      else if (rd && sda_i) act = 1'b0;
      bitn = bitn + 1;
   end
   // The line changes right after scl falls, the shortest hold a real part may give.
   always @(negedge scl_i) if (act) begin
      if (bitn == 9) begin
         bitn = 0;
         rd = go_rd;
         if (rd) begin
            tx = mem[ptr];
            ptr = ptr + 7'h01;
         end
      end
      if (rd) sda_oe_o = (bitn < 8) && !tx[7 - bitn];
      else if (bitn == 8) begin
         if (first) begin
            ok = ((sh | 8'h01) == `FPC_EE_DEV_RD) && !nack_i;
            go_rd = sh[0];
         end else ptr = sh[6:0];
         first = 1'b0;
         sda_oe_o = ok;
         act = ok;
      end else sda_oe_o = 1'b0;
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the fault indicator and its boot loader.
// Assumes the memory model is compiled first; both lines have pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fpc_pkg::*;
   localparam int PER = 64;
   localparam int NB = 4;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [11:0] amp_i = 12'h000;
   logic [11:0] supply_i = 12'h1f4;
   logic [19:0] freq_hz_i = 20'h00000;
   logic [19:0] freq_max_hz_i = 20'h01388;
   logic [13:0] resolution_i = 14'h2000;
   logic nack = 1'b0;
   logic scl_oe, sda_oe, ee_oe, cfg_ready_o, cfg_we_o, fault_n_o;
   wire logic scl;
   wire logic sda;
   logic [6:0] cfg_addr_o;
   logic [7:0] cfg_data_o;
   fpc_fault_e fault_kind_o;
   logic [15:0] exp_q [$];
   logic [31:0] seed = 32'h75f9;
   int miscompares = 0;
   int num_checks = 0;
   logic sda_val;
   logic scl_val;
   logic [11:0] ra;
   logic [19:0] rf;
   fpc_fault_e rk;
   int rl;
   assign scl = ~scl_oe;
   assign sda = ~(sda_oe | ee_oe);
   always #25 core_clk_i = ~core_clk_i;
   // ----------------------------------------
   // Design and memory
   // ----------------------------------------
   fpc_fault_pwm #(.PWM_PERIOD(PER), .I2C_QTR(2), .CFG_BYTES(NB)) u_dut (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .amp_i(amp_i), .supply_i(supply_i),
      .freq_hz_i(freq_hz_i), .freq_max_hz_i(freq_max_hz_i), .resolution_i(resolution_i),
      .ee_sda_i(sda), .ee_sda_o(sda_val), .ee_sda_oe_o(sda_oe), .ee_scl_o(scl_val),
      .ee_scl_oe_o(scl_oe),
      .fault_n_o(fault_n_o), .fault_kind_o(fault_kind_o), .cfg_ready_o(cfg_ready_o),
      .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o));
   fpc_ee_model #(.MEM_BYTES(128)) u_ee (.scl_i(scl), .sda_i(sda), .nack_i(nack),
      .sda_oe_o(ee_oe));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_for(input logic want_fail);
      int n;
      n = 0;
      while (n < 4000 && (want_fail ? fault_kind_o !== FPC_FLT_CFG : cfg_ready_o !== 1'b1)) begin
         @(posedge core_clk_i);
         n++;
      end
      #1;
   endtask
   // Counting both levels keeps an unknown indicator from passing as high.
   task automatic run_case(input logic [11:0] a, input logic [11:0] s, input logic [19:0] f,
                           input logic [19:0] fm, input logic [13:0] r,
                           input fpc_fault_e kind, input int lows);
      int lo;
      int hi;
      lo = 0;
      hi = 0;
      @(posedge core_clk_i);
      amp_i <= a;
      supply_i <= s;
      freq_hz_i <= f;
      freq_max_hz_i <= fm;
      resolution_i <= r;
      repeat (4) @(posedge core_clk_i);
      #1;
      check({14'h0000, fault_kind_o}, {14'h0000, kind});
      repeat (PER) begin
         lo += (fault_n_o === 1'b0);
         hi += (fault_n_o === 1'b1);
         @(posedge core_clk_i);
         #1;
      end
      check({lo[7:0], hi[7:0]}, {8'(lows), 8'(PER - lows)});
   endtask
   // ----------------------------------------
   // Result monitor and watchdog
   // ----------------------------------------
   // Sampled mid-cycle so the registered strobe and its data have settled.
   always @(negedge core_clk_i) begin
      if (cfg_we_o === 1'b1) begin
         if (exp_q.size() == 0) check(16'h0001, 16'h0000);
         else check({1'b0, cfg_addr_o, cfg_data_o}, exp_q.pop_front());
      end
   end
   initial begin
      #1000000;
      miscompares++;
      print_verdict();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 128; i++) begin
         seed = lfsr_next(seed);
         u_ee.mem[i] = seed[7:0];
         if (i < NB) exp_q.push_back({1'b0, 7'(i), seed[7:0]});
      end
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      wait_for(1'b0);
      check({15'h0000, cfg_ready_o}, 16'h0001);
      check(16'(exp_q.size()), 16'h0000);
      check({14'h0000, sda_val, scl_val}, 16'h0000);
      run_case(12'h032, 12'h1f4, 20'h01388, 20'h01388, 14'h2000, FPC_FLT_NONE, 0);
      run_case(12'h028, 12'h1f4, 20'h01388, 20'h01388, 14'h2000, FPC_FLT_LOW_AMP, 48);
      run_case(12'hfff, 12'h1f4, 20'h01388, 20'h01388, 14'h2000, FPC_FLT_NONE, 0);
      run_case(12'h032, 12'h1f4, 20'h01389, 20'h01388, 14'h2000, FPC_FLT_OVERSPEED, 32);
      run_case(12'h032, 12'h1f4, 20'h003e9, 20'h186a0, 14'h0fff, FPC_FLT_OVERSPEED, 32);
      run_case(12'h032, 12'h1f4, 20'h003e8, 20'h186a0, 14'h0fff, FPC_FLT_NONE, 0);
      run_case(12'h032, 12'h1f4, 20'h003e9, 20'h186a0, 14'h1000, FPC_FLT_NONE, 0);
      run_case(12'h028, 12'h1f4, 20'h01389, 20'h01388, 14'h2000, FPC_FLT_LOW_AMP, 48);
      // Random amplitude and frequency around both thresholds at a small resolution.
      for (int k = 0; k < 6; k++) begin
         seed = lfsr_next(seed);
         ra = {5'h00, seed[6:0]};
         rf = {8'h00, seed[19:8]};
         if (({4'h0, ra} * 16'h000a) < 16'h01f4) rk = FPC_FLT_LOW_AMP;
         else if (rf > 20'h003e8) rk = FPC_FLT_OVERSPEED;
         else rk = FPC_FLT_NONE;
         rl = (rk == FPC_FLT_LOW_AMP) ? PER * 3 / 4 : ((rk == FPC_FLT_OVERSPEED) ? PER / 2 : 0);
         run_case(ra, 12'h1f4, rf, 20'h186a0, 14'h0fff, rk, rl);
      end
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      nack <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      wait_for(1'b1);
      run_case(12'h028, 12'h1f4, 20'h01389, 20'h01388, 14'h2000, FPC_FLT_CFG, PER);
      check({15'h0000, cfg_ready_o}, 16'h0000);
      print_verdict();
   end
endmodule
`default_nettype wire
